// >>> dv/cme_chan_model.sv
module cme_chan_model
  import cme_pkg::*;
(
  input  wire logic       mclk_in,
  input  wire logic       resetn_in,
  input  wire logic       stall_in,
  input  wire logic       order_strobe_in,
  input  wire cme_order_t order_in,
  input  wire cme_word_t  order_command_word_in,
  input  wire cme_word_t  order_address_word_in,
  output logic            wr_valid_out,
  input  wire logic       wr_ready_in,
  output cme_word_t       wr_data_out,
  input  wire logic       rd_valid_in,
  output logic            rd_ready_out,
  input  wire cme_word_t  rd_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  cme_word_t  wq[$];
  cme_word_t  got[$];
  logic [1:0] bank;
  cme_word_t  moved;
  cme_word_t  residue;
  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_valid_out <= 1'b0;
      wr_data_out <= 16'h0000;
      rd_ready_out <= 1'b0;
      bank <= 2'h0;
      moved <= 16'h0000;
      residue <= 16'h0000;
    end else begin
      if (rd_valid_in && rd_ready_out) got.push_back(rd_data_in);
      rd_ready_out <= !stall_in;
      if (wr_valid_out && wr_ready_in) moved <= moved + 16'h0001;
      // A word stays offered until taken; idle data toggles so it is never reused
      if (!wr_valid_out || wr_ready_in) begin
        wr_valid_out <= wq.size() > 0;
        wr_data_out <= (wq.size() > 0) ? wq.pop_front() : ~wr_data_out;
      end
      if (order_strobe_in && order_in == CME_ORD_BANK && order_command_word_in[4]) begin
        bank <= order_address_word_in[15:14];
      end
      if (order_strobe_in && order_in == CME_ORD_RESIDUE && !order_command_word_in[4]) begin
        residue <= moved;
      end
    end
  end
endmodule

// >>> dv/cme_top_asserts.sv
module cme_top_asserts
  import cme_pkg::*;
(
  input wire logic       mclk_in,
  input wire logic       resetn_in,
  input wire logic       io_reset_in,
  input wire logic       dio_strobe_in,
  input wire cme_dio_t   dio_cmd_in,
  input wire cme_word_t  stack_top_in,
  input wire logic       channel_idle_signal_in,
  input wire logic       order_strobe_in,
  input wire cme_order_t order_in,
  input wire cme_word_t  order_command_word_in,
  input wire cme_word_t  order_address_word_in,
  input wire logic       dio_done_out,
  input wire logic       sio_reject_out,
  input wire logic       channel_ack_out,
  input wire logic       jump_condition_met_out,
  input wire logic       program_end_out,
  input wire logic       device_end_out,
  input wire logic       clear_interface_request_out,
  input wire logic       service_request_out,
  input wire logic       irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (!resetn_in);
  // I/O reset overrides every flag but the interrupt request, so it is kept out of the triggers
  logic dio_v;
  logic ord_v;
  assign dio_v = dio_strobe_in && !io_reset_in;
  assign ord_v = order_strobe_in && !io_reset_in;
  sequence s_dend_cfg;
    dio_v && dio_cmd_in == CME_DIO_CIO && stack_top_in[3] && !stack_top_in[0];
  endsequence
  sequence s_wr_start;
    ord_v && order_in == CME_ORD_WRITE;
  endsequence
  property p_set_mask_instr;
    dio_v && dio_cmd_in == CME_DIO_SET_MASK_INSTR |=> dio_done_out && $stable(irq_out) && !sio_reject_out;
  endproperty
  a_set_mask_instr: assert property (p_set_mask_instr)
    else $error("mask instruction changed state");
  property p_irq_set;
    (dio_v && dio_cmd_in == CME_DIO_SIN) || (ord_v && order_in == CME_ORD_INTR) |=> irq_out;
  endproperty
  a_irq_set: assert property (p_irq_set)
    else $error("interrupt request not set");
  property p_sio;
    dio_v && dio_cmd_in == CME_DIO_SIO |=> sio_reject_out != $past(channel_idle_signal_in);
  endproperty
  a_sio: assert property (p_sio)
    else $error("start reject does not follow channel state");
  property p_end;
    ord_v && order_in == CME_ORD_END && order_command_word_in[4] |=> program_end_out && irq_out;
  endproperty
  a_end: assert property (p_end)
    else $error("end order without end pulse or interrupt");
  property p_noack;
    ord_v && order_in == CME_ORD_CONTROL && order_address_word_in[4] |=> !channel_ack_out;
  endproperty
  a_noack: assert property (p_noack)
    else $error("acknowledge not withheld");
  property p_jump;
    ord_v && order_in == CME_ORD_JUMP && order_command_word_in[4] && order_command_word_in[2]
      |=> jump_condition_met_out;
  endproperty
  a_jump: assert property (p_jump)
    else $error("jump not met");
  property p_nosr;
    ord_v && order_in == CME_ORD_CONTROL && order_address_word_in[5] && !order_address_word_in[0]
      |=> !service_request_out;
  endproperty
  a_nosr: assert property (p_nosr)
    else $error("service request not withheld");
  property p_mrst;
    dio_v && dio_cmd_in == CME_DIO_CIO && stack_top_in[0] && !channel_idle_signal_in
      |=> clear_interface_request_out ##1
          (clear_interface_request_out || $past(dio_strobe_in) || $past(io_reset_in));
  endproperty
  a_mrst: assert property (p_mrst)
    else $error("clear interface missing after master reset");
  property p_devend;
    s_dend_cfg ##1 (!dio_strobe_in && !order_strobe_in && !io_reset_in) ##1 s_wr_start
      |=> device_end_out;
  endproperty
  a_devend: assert property (p_devend)
    else $error("device end missing at transfer start");
endmodule

bind cme_top cme_top_asserts u_chk (
  .mclk_in, .resetn_in, .io_reset_in, .dio_strobe_in, .dio_cmd_in, .stack_top_in,
  .channel_idle_signal_in, .order_strobe_in, .order_in, .order_command_word_in,
  .order_address_word_in, .dio_done_out, .sio_reject_out, .channel_ack_out,
  .jump_condition_met_out, .program_end_out, .device_end_out,
  .clear_interface_request_out, .service_request_out, .irq_out
);

// >>> dv/cme_top_tb_top.sv
module cme_top_tb_top
  import cme_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk_in, resetn_in, io_reset_in, dio_strobe_in, channel_idle_signal_in;
  logic       order_strobe_in, eot_in, rd_ready_in, wr_valid_in, stall;
  cme_dio_t   dio_cmd_in;
  cme_order_t order_in;
  cme_word_t  stack_top_in, order_command_word_in, order_address_word_in, wr_data_in;
  cme_word_t  stack_top_out, rd_data_out;
  logic       dio_done_out, sio_reject_out, program_start_out, channel_ack_out;
  logic       jump_condition_met_out, program_end_out, device_end_out, wr_ready_out;
  logic       clear_interface_request_out, compare_fail_out, rd_valid_out;
  logic       service_request_out, irq_out;
  int         err_total = 0;
  int         cmp_count = 0;
  cme_top dut (
    .mclk_in, .resetn_in, .io_reset_in, .dio_strobe_in, .dio_cmd_in, .stack_top_in,
    .stack_top_out, .dio_done_out, .sio_reject_out, .program_start_out,
    .channel_idle_signal_in, .order_strobe_in, .order_in, .order_command_word_in,
    .order_address_word_in, .xfer_error_in(1'b0), .eot_in, .channel_ack_out,
    .jump_condition_met_out, .program_end_out, .device_end_out,
    .clear_interface_request_out, .compare_fail_out, .wr_valid_in, .wr_ready_out,
    .wr_data_in, .rd_valid_out, .rd_ready_in, .rd_data_out, .service_request_out, .irq_out
  );
  cme_chan_model chan (
    .mclk_in, .resetn_in, .stall_in(stall), .order_strobe_in, .order_in,
    .order_command_word_in, .order_address_word_in, .wr_valid_out(wr_valid_in),
    .wr_ready_in(wr_ready_out), .wr_data_out(wr_data_in), .rd_valid_in(rd_valid_out),
    .rd_ready_out(rd_ready_in), .rd_data_in(rd_data_out)
  );
  always #25 mclk_in = ~mclk_in;
  task automatic chk(input cme_word_t seen, input cme_word_t exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t ns: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic dio(input cme_dio_t c, input cme_word_t w);
    @(posedge mclk_in);
    dio_strobe_in <= 1'b1;
    dio_cmd_in <= c;
    stack_top_in <= w;
    @(posedge mclk_in);
    dio_strobe_in <= 1'b0;
    #1;
  endtask
  task automatic ord(input cme_order_t o, input cme_word_t cw, input cme_word_t aw);
    @(posedge mclk_in);
    order_strobe_in <= 1'b1;
    order_in <= o;
    order_command_word_in <= cw;
    order_address_word_in <= aw;
    @(posedge mclk_in);
    order_strobe_in <= 1'b0;
    #1;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic set_idle(input logic v);
    @(posedge mclk_in);
    channel_idle_signal_in <= v;
  endtask
  task automatic pulse(input logic is_eot);
    @(posedge mclk_in);
    if (is_eot) eot_in <= 1'b1;
    else io_reset_in <= 1'b1;
    @(posedge mclk_in);
    eot_in <= 1'b0;
    io_reset_in <= 1'b0;
    #1;
  endtask
  // Bounded wait: a device that stops taking words must not hang the run
  task automatic drain;
    for (int i = 0; i < 20; i++) begin
      @(posedge mclk_in);
      #1;
      if (chan.wq.size() == 0 && wr_valid_in === 1'b0) break;
    end
    chk(16'(chan.wq.size()) + 16'(wr_valid_in), 16'h0000);
  endtask
  task automatic summarize;
    $display("mismatches %0d, comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge mclk_in);
    err_total++;
    summarize();
  end
  initial begin
    mclk_in = 1'b0;
    resetn_in = 1'b0;
    {io_reset_in, dio_strobe_in, order_strobe_in, eot_in, stall} = 5'h00;
    channel_idle_signal_in = 1'b1;
    dio_cmd_in = CME_DIO_NONE;
    order_in = CME_ORD_NONE;
    {stack_top_in, order_command_word_in, order_address_word_in} = 48'h0;
    repeat (6) @(posedge mclk_in);
    resetn_in <= 1'b1;
    dio(CME_DIO_TIO, 16'h0000);
    chk(stack_top_out, 16'h0023);
    dio(CME_DIO_RIO, 16'h0000);
    chk(stack_top_out, 16'h0000);
    dio(CME_DIO_WIO, 16'hA5C3);
    dio(CME_DIO_RIO, 16'h0000);
    chk(stack_top_out, 16'hA5C3);
    dio(CME_DIO_SIN, 16'h0000);
    chk(irq_out, 16'h1);
    dio(CME_DIO_CIO, 16'h0002);
    chk(irq_out, 16'h0);
    ord(CME_ORD_INTR, 16'h0000, 16'h0000);
    chk(irq_out, 16'h1);
    dio(CME_DIO_SET_MASK_INSTR, 16'hFFFF);
    chk({dio_done_out, irq_out}, 16'h3);
    set_idle(1'b0);
    dio(CME_DIO_SIO, 16'h0000);
    chk({sio_reject_out, program_start_out}, 16'h2);
    set_idle(1'b1);
    dio(CME_DIO_SIO, 16'h0000);
    chk({sio_reject_out, program_start_out}, 16'h1);
    ord(CME_ORD_CONTROL, 16'h0000, 16'h0010);
    chk(channel_ack_out, 16'h0);
    ord(CME_ORD_JUMP, 16'h0000, 16'h0000);
    chk(jump_condition_met_out, 16'h0);
    ord(CME_ORD_CONTROL, 16'h0010, 16'h0000);
    chk(channel_ack_out, 16'h1);
    ord(CME_ORD_JUMP, 16'h0000, 16'h0000);
    chk(jump_condition_met_out, 16'h1);
    dio(CME_DIO_CIO, 16'h0010);
    ord(CME_ORD_JUMP, 16'h0000, 16'h0000);
    chk(jump_condition_met_out, 16'h0);
    ord(CME_ORD_JUMP, 16'h0014, 16'h0000);
    chk(jump_condition_met_out, 16'h1);
    dio(CME_DIO_CIO, 16'h0014);
    ord(CME_ORD_JUMP, 16'h0000, 16'h0000);
    chk(jump_condition_met_out, 16'h1);
    ord(CME_ORD_BANK, 16'h0010, 16'hC000);
    chk({chan.bank, channel_ack_out}, 16'h7);
    ord(CME_ORD_RESIDUE, 16'h0000, 16'h0000);
    chk(channel_ack_out, 16'h1);
    set_idle(1'b0);
    dio(CME_DIO_CIO, 16'h0001);
    chk(clear_interface_request_out, 16'h1);
    dio(CME_DIO_RIO, 16'h0000);
    chk(stack_top_out, 16'h0000);
    set_idle(1'b1);
    pulse(1'b0);
    dio(CME_DIO_CIO, 16'h0001);
    chk(clear_interface_request_out, 16'h0);
    ord(CME_ORD_WRITE, 16'h0000, 16'h0000);
    chan.wq = '{16'h1111, 16'h2222};
    drain();
    pulse(1'b1);
    dio(CME_DIO_RIO, 16'h0000);
    chk(stack_top_out, 16'h2222);
    ord(CME_ORD_RESIDUE, 16'h0000, 16'h0000);
    chk(chan.residue, 16'h0002);
    dio(CME_DIO_CIO, 16'h0800);
    ord(CME_ORD_WRITE, 16'h0000, 16'h0000);
    chan.wq.push_back(16'h2222);
    drain();
    chk(compare_fail_out, 16'h0);
    chan.wq.push_back(16'h3333);
    drain();
    settle(1);
    chk(compare_fail_out, 16'h1);
    pulse(1'b1);
    dio(CME_DIO_RIO, 16'h0000);
    chk(stack_top_out, 16'h2222);
    dio(CME_DIO_CIO, 16'h0008);
    ord(CME_ORD_WRITE, 16'h0000, 16'h0000);
    chk({device_end_out, wr_ready_out}, 16'h2);
    pulse(1'b1);
    dio(CME_DIO_CIO, 16'h0000);
    dio(CME_DIO_WIO, 16'hBEEF);
    stall <= 1'b1;
    ord(CME_ORD_READ, 16'h0000, 16'h0000);
    settle(6);
    chk(16'(chan.got.size()), 16'h0);
    stall <= 1'b0;
    settle(6);
    pulse(1'b1);
    chk(chan.got[0], 16'hBEEF);
    chk(chan.got[$], 16'hBEEF);
    ord(CME_ORD_CONTROL, 16'h0000, 16'h0020);
    ord(CME_ORD_READ, 16'h0000, 16'h0000);
    chk(service_request_out, 16'h0);
    pulse(1'b1);
    pulse(1'b0);
    dio(CME_DIO_RIO, 16'h0000);
    chk(stack_top_out, 16'h0000);
    chan.got.delete();
    ord(CME_ORD_SENSE, 16'h0000, 16'h0000);
    settle(2);
    chk(chan.got[0], 16'h0023);
    ord(CME_ORD_END, 16'h0010, 16'h0000);
    chk({program_end_out, irq_out}, 16'h3);
    settle(2);
    chk(16'(chan.got.size()), 16'h2);
    summarize();
  end
endmodule

// >>> hw/cme_buf2.sv
`include "cme_defines.svh"
module cme_buf2
  import cme_pkg::*;
(
  input  wire logic      mclk_in,
  input  wire logic      resetn_in,
  input  wire logic      flush_in,
  input  wire logic      in_valid_in,
  output logic           in_ready_out,
  input  wire cme_word_t in_data_in,
  output logic           out_valid_out,
  input  wire logic      out_ready_in,
  output cme_word_t      out_data_out
);
  cme_word_t mem [2];
  logic      wr_ptr;
  logic      rd_ptr;
  logic [1:0] count;
  logic      push;
  logic      pop;

  assign in_ready_out  = (count != 2'h2);
  assign out_valid_out = (count != 2'h0);
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;
  assign out_data_out  = mem[rd_ptr];

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mem[0] <= `CME_ZERO;
      mem[1] <= `CME_ZERO;
    end else if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else if (flush_in) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      if (push) wr_ptr <= ~wr_ptr;
      if (pop) rd_ptr <= ~rd_ptr;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// >>> hw/cme_defines.svh
// Behaviour
// - Set-interrupt instruction and Interrupt order both set the interrupt request flop.
// - Control-out instruction loads the stack-top word into the control register.
// - Start-program runs only when channel idle; otherwise it is rejected.
// - Write-direct instruction loads the stack-top word into the counter/buffer.
// - Read-direct instruction returns counter/buffer contents to stack top.
// - Test-status instruction returns the 16-bit status word to stack top.
// - Set-mask instruction is ignored; there is no mask flop.
// - Write order loads counter/buffer, or compares against it when control bit 11 set.
// - Read order sends counter/buffer contents to the channel for memory.
// - End order returns status, ends the program, interrupts when order bit 4 set.
// - Sense order supplies the status word for storage in memory.
// - Jump taken if order bit 4 and command bit 2, or control bit 4 clear.
// - Control order stores address word in control register, ignores command word.
// - Control bit 0 resets logic, control and buffer; clear interface if channel busy.
// - Control bit 1 written as 1 clears the interrupt request flop.
// - Control bit 2 sets jump flop; conditional Jump then gets jump met.
// - Control bit 3 forces Device End at start of every data transfer.
// - Control bit 4 withholds Channel Acknowledge after the current Control order.
// - Control bit 5 withholds Channel Service Request from later orders.
// - I/O Reset clears the counter/buffer and the control word to zero.
`ifndef CME_DEFINES_SVH
`define CME_DEFINES_SVH
`define CME_W          16
`define CME_ZERO       16'h0000
`define CME_C_MRST     0
`define CME_C_RINT     1
`define CME_C_JUMP     2
`define CME_C_DEVEND   3
`define CME_C_NOACK    4
`define CME_C_NOSR     5
`define CME_C_COMPARE  11
`define CME_O_BIT4     4
`define CME_CW_BIT2    2
`define CME_S_SIOOK    0
`define CME_S_RWOK     1
`define CME_S_IRQ      2
`define CME_S_IACT     3
`define CME_S_XERR     4
`define CME_S_IDLE     5
`define CME_S_DEVEND   6
`define CME_S_EOT      7
`define CME_S_INX      8
`define CME_S_OUTX     9
`define CME_S_NOCMP    11
`define CME_S_CLRIF    12
`endif

// >>> hw/cme_pkg.sv
`include "cme_defines.svh"
package cme_pkg;
  typedef logic [`CME_W-1:0] cme_word_t;
  typedef enum logic [3:0] {
    CME_ORD_NONE, CME_ORD_CONTROL, CME_ORD_WRITE, CME_ORD_READ, CME_ORD_END,
    CME_ORD_INTR, CME_ORD_SENSE, CME_ORD_JUMP, CME_ORD_RESIDUE, CME_ORD_BANK
  } cme_order_t;
  typedef enum logic [2:0] {
    CME_DIO_NONE, CME_DIO_SIN, CME_DIO_CIO, CME_DIO_SIO,
    CME_DIO_WIO, CME_DIO_RIO, CME_DIO_TIO, CME_DIO_SET_MASK_INSTR
  } cme_dio_t;
  typedef enum {CME_ST_IDLE, CME_ST_RUN} cme_state_t;
endpackage

// >>> hw/cme_top.sv
`include "cme_defines.svh"
module cme_top
  import cme_pkg::*;
(
  input  wire logic       mclk_in,
  input  wire logic       resetn_in,
  input  wire logic       io_reset_in,
  // Direct I/O from the processor
  input  wire logic       dio_strobe_in,
  input  wire cme_dio_t   dio_cmd_in,
  input  wire cme_word_t  stack_top_in,
  output cme_word_t       stack_top_out,
  output logic            dio_done_out,
  output logic            sio_reject_out,
  output logic            program_start_out,
  // Channel order interface
  input  wire logic       channel_idle_signal_in,
  input  wire logic       order_strobe_in,
  input  wire cme_order_t order_in,
  input  wire cme_word_t  order_command_word_in,
  input  wire cme_word_t  order_address_word_in,
  input  wire logic       xfer_error_in,
  input  wire logic       eot_in,
  output logic            channel_ack_out,
  output logic            jump_condition_met_out,
  output logic            program_end_out,
  output logic            device_end_out,
  output logic            clear_interface_request_out,
  output logic            compare_fail_out,
  // Write data words from the channel
  input  wire logic       wr_valid_in,
  output logic            wr_ready_out,
  input  wire cme_word_t  wr_data_in,
  // Read data and status words toward the channel
  output logic            rd_valid_out,
  input  wire logic       rd_ready_in,
  output cme_word_t       rd_data_out,
  output logic            service_request_out,
  output logic            irq_out
);
  cme_word_t  control;
  cme_word_t  counter_buf;
  cme_order_t xfer_order;
  cme_state_t state;
  logic       irq_flag;
  logic       jump_ff;
  logic       devend_ff;
  logic       clrif_ff;
  logic       nocmp_ff;
  logic       xerr_ff;
  logic       eot_ff;
  logic       in_xfer;
  logic       out_xfer;
  logic       push_valid;
  logic       push_ready;
  cme_word_t  push_data;
  logic       flush;
  cme_word_t  status;

  // Decoded strobes
  logic is_cio;
  logic is_sin;
  logic is_sio;
  logic is_wio;
  logic is_ctl_order;
  logic ctl_load;
  cme_word_t ctl_word;
  logic mreset;
  logic xfer_start;
  logic wr_take;

  function automatic logic dio_is(input logic stb, input cme_dio_t c, input cme_dio_t k);
    dio_is = stb && (c == k);
  endfunction

  function automatic logic ord_is(input logic stb, input cme_order_t o, input cme_order_t k);
    ord_is = stb && (o == k);
  endfunction

  assign is_cio       = dio_is(dio_strobe_in, dio_cmd_in, CME_DIO_CIO);
  assign is_sin       = dio_is(dio_strobe_in, dio_cmd_in, CME_DIO_SIN);
  assign is_sio       = dio_is(dio_strobe_in, dio_cmd_in, CME_DIO_SIO);
  assign is_wio       = dio_is(dio_strobe_in, dio_cmd_in, CME_DIO_WIO);
  assign is_ctl_order = ord_is(order_strobe_in, order_in, CME_ORD_CONTROL);
  assign ctl_load     = is_cio || is_ctl_order;
  // Command word of a Control order is deliberately unused
  assign ctl_word     = is_cio ? stack_top_in : order_address_word_in;
  assign mreset       = ctl_load && ctl_word[`CME_C_MRST];
  assign xfer_start   = ord_is(order_strobe_in, order_in, CME_ORD_WRITE) ||
                        ord_is(order_strobe_in, order_in, CME_ORD_READ);
  assign wr_take      = wr_valid_in && (xfer_order == CME_ORD_WRITE) && !devend_ff;
  assign wr_ready_out = (xfer_order == CME_ORD_WRITE) && !devend_ff;
  assign flush        = mreset || io_reset_in;

  always_comb begin
    status = `CME_ZERO;
    status[`CME_S_SIOOK]  = (state == CME_ST_IDLE) && channel_idle_signal_in;
    status[`CME_S_RWOK]   = 1'b1;
    status[`CME_S_IRQ]    = irq_flag;
    status[`CME_S_IACT]   = irq_flag;
    status[`CME_S_XERR]   = xerr_ff;
    status[`CME_S_IDLE]   = channel_idle_signal_in;
    status[`CME_S_DEVEND] = devend_ff;
    status[`CME_S_EOT]    = eot_ff;
    status[`CME_S_INX]    = in_xfer;
    status[`CME_S_OUTX]   = out_xfer;
    status[`CME_S_NOCMP]  = nocmp_ff;
    status[`CME_S_CLRIF]  = clrif_ff;
  end

  // Control register: I/O reset and master reset both clear it
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      control <= `CME_ZERO;
    end else if (io_reset_in || mreset) begin
      control <= `CME_ZERO;
    end else if (ctl_load) begin
      control <= ctl_word;
    end
  end

  // Counter/buffer
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      counter_buf <= `CME_ZERO;
    end else if (io_reset_in || mreset) begin
      counter_buf <= `CME_ZERO;
    end else if (is_wio) begin
      counter_buf <= stack_top_in;
    end else if (wr_take && !control[`CME_C_COMPARE]) begin
      counter_buf <= wr_data_in;
    end
  end

  // Interrupt request: a set in the same cycle as a clear wins
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_flag <= 1'b0;
    end else if (is_sin || ord_is(order_strobe_in, order_in, CME_ORD_INTR) ||
                 (ord_is(order_strobe_in, order_in, CME_ORD_END) &&
                  order_command_word_in[`CME_O_BIT4])) begin
      irq_flag <= 1'b1;
    end else if (io_reset_in || mreset ||
                 (ctl_load && ctl_word[`CME_C_RINT])) begin
      irq_flag <= 1'b0;
    end
  end
  assign irq_out = irq_flag;

  // Jump flop stays set until a reset or a new control word clears bit 2
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      jump_ff <= 1'b0;
    end else if (io_reset_in || mreset) begin
      jump_ff <= 1'b0;
    end else if (ctl_load) begin
      jump_ff <= ctl_word[`CME_C_JUMP];
    end
  end

  // Program state and start handling; set-mask falls through untouched
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= CME_ST_IDLE;
    end else if (io_reset_in || mreset) begin
      state <= CME_ST_IDLE;
    end else begin
      case (state)
        CME_ST_IDLE: if (is_sio && channel_idle_signal_in) state <= CME_ST_RUN;
        CME_ST_RUN:  if (ord_is(order_strobe_in, order_in, CME_ORD_END)) state <= CME_ST_IDLE;
        default:     state <= CME_ST_IDLE;
      endcase
    end
  end

  // Transfer tracking and sticky status; hardware set beats only the start-program clear
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      xfer_order <= CME_ORD_NONE;
      devend_ff  <= 1'b0;
      nocmp_ff   <= 1'b0;
      eot_ff     <= 1'b0;
      xerr_ff    <= 1'b0;
      clrif_ff   <= 1'b0;
      in_xfer    <= 1'b0;
      out_xfer   <= 1'b0;
    end else if (io_reset_in || (is_sio && channel_idle_signal_in)) begin
      // A flag event landing with the start-program clear still sets its flag
      xfer_order <= CME_ORD_NONE;
      devend_ff  <= 1'b0;
      nocmp_ff   <= !io_reset_in && wr_take && control[`CME_C_COMPARE] &&
                    (wr_data_in != counter_buf);
      eot_ff     <= !io_reset_in && eot_in;
      xerr_ff    <= !io_reset_in && xfer_error_in;
      clrif_ff   <= 1'b0;
      in_xfer    <= 1'b0;
      out_xfer   <= 1'b0;
    end else begin
      if (xfer_start) begin
        xfer_order <= order_in;
        devend_ff  <= control[`CME_C_DEVEND];
        nocmp_ff   <= 1'b0;
        eot_ff     <= 1'b0;
        in_xfer    <= (order_in == CME_ORD_READ);
        out_xfer   <= (order_in == CME_ORD_WRITE);
      end else begin
        if (eot_in) xfer_order <= CME_ORD_NONE;
        if (eot_in) eot_ff <= 1'b1;
        if (wr_take && control[`CME_C_COMPARE] && (wr_data_in != counter_buf))
          nocmp_ff <= 1'b1;
      end
      if (xfer_error_in) xerr_ff <= 1'b1;
      if (mreset && !channel_idle_signal_in) clrif_ff <= 1'b1;
    end
  end

  // Words toward the channel pass a two-entry buffer; a word offered while it is full is dropped
  always_comb begin
    push_valid = 1'b0;
    push_data  = counter_buf;
    if (ord_is(order_strobe_in, order_in, CME_ORD_END) ||
        ord_is(order_strobe_in, order_in, CME_ORD_SENSE)) begin
      push_valid = 1'b1;
      push_data  = status;
    end else if ((xfer_order == CME_ORD_READ) && !devend_ff && !xfer_start) begin
      push_valid = 1'b1;
      push_data  = counter_buf;
    end
  end

  cme_buf2 u_buf (
    .mclk_in       (mclk_in),
    .resetn_in     (resetn_in),
    .flush_in      (flush),
    .in_valid_in   (push_valid),
    .in_ready_out  (push_ready),
    .in_data_in    (push_data),
    .out_valid_out (rd_valid_out),
    .out_ready_in  (rd_ready_in),
    .out_data_out  (rd_data_out)
  );

  // Service request follows data readiness; control bit 5 withholds it
  assign service_request_out = !control[`CME_C_NOSR] &&
                               ((xfer_order == CME_ORD_READ && push_ready && !devend_ff) ||
                                wr_ready_out);

  // Registered answers toward the processor
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      dio_done_out      <= 1'b0;
      sio_reject_out    <= 1'b0;
      program_start_out <= 1'b0;
    end else begin
      dio_done_out      <= dio_strobe_in;
      sio_reject_out    <= is_sio && !channel_idle_signal_in;
      program_start_out <= is_sio && channel_idle_signal_in && (state == CME_ST_IDLE);
    end
  end

  // Stack-top answer holds until the next read-direct or test-status
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      stack_top_out <= `CME_ZERO;
    end else if (dio_is(dio_strobe_in, dio_cmd_in, CME_DIO_RIO)) begin
      stack_top_out <= counter_buf;
    end else if (dio_is(dio_strobe_in, dio_cmd_in, CME_DIO_TIO)) begin
      stack_top_out <= status;
    end
  end

  // Registered answers toward the channel
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      channel_ack_out        <= 1'b0;
      jump_condition_met_out <= 1'b0;
      program_end_out        <= 1'b0;
    end else begin
      // Ack withheld only for a Control order that sets bit 4 itself
      channel_ack_out <= order_strobe_in &&
                         !(is_ctl_order && ctl_word[`CME_C_NOACK]);
      jump_condition_met_out <= ord_is(order_strobe_in, order_in, CME_ORD_JUMP) &&
                                ((order_command_word_in[`CME_O_BIT4] &&
                                  order_command_word_in[`CME_CW_BIT2]) ||
                                 !control[`CME_C_NOACK] || jump_ff);
      program_end_out <= ord_is(order_strobe_in, order_in, CME_ORD_END);
    end
  end

  // Straight from their flops so the channel sees them one cycle after the cause
  assign device_end_out              = devend_ff && (xfer_order != CME_ORD_NONE);
  assign clear_interface_request_out = clrif_ff;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      compare_fail_out <= 1'b0;
    end else begin
      compare_fail_out <= nocmp_ff;
    end
  end
endmodule
